// [ldb_pkg.sv]
// Constants shared by the LED brightness engine: register map, field
// positions, reset values and timing counts.
// Assumes a 100 MHz core clock.
package ldb_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [4:0] ADDR_MODE1 = 5'h00;
    localparam logic [4:0] ADDR_SECOND_MODE = 5'h01;
    localparam logic [4:0] ADDR_LED0_DUTY = 5'h02;
    localparam logic [4:0] ADDR_GROUP_DUTY = 5'h0a;
    localparam logic [4:0] ADDR_GROUP_PERIOD = 5'h0b;
    localparam logic [4:0] ADDR_SRC_LOW = 5'h0c;
    localparam logic [4:0] ADDR_SRC_HIGH = 5'h0d;
    localparam int NUM_CHAN = 8;
    localparam int NUM_STAGED = 12;
    localparam logic [3:0] IDX_GROUP_DUTY = 4'h8;
    localparam logic [3:0] IDX_GROUP_PERIOD = 4'h9;
    localparam logic [3:0] IDX_SRC_LOW = 4'ha;
    localparam logic [3:0] IDX_SRC_HIGH = 4'hb;

    // ----------------------------------------------------------------
    // Fields and reset values
    // ----------------------------------------------------------------
    localparam int MODE1_SLEEP_BIT = 4;
    localparam logic [4:0] MODE1_RESET = 5'h11;
    localparam logic [4:0] MODE1_WR_MASK = 5'h1f;
    localparam int GROUP_BLINK_BIT = 5;
    localparam int UPDATE_ON_ACK_BIT = 3;
    localparam logic [7:0] GROUP_DUTY_RESET = 8'hff;
    localparam logic [7:0] DEFAULT_RESET = 8'h00;

    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_FULL_ON = 2'h1;
    localparam logic [1:0] SRC_CHAN_PWM = 2'h2;
    localparam logic [1:0] SRC_CHAN_GROUP = 2'h3;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int PWM_STEPS = 256;
    localparam int CHAN_PWM_HZ = 97_000;
    localparam int CHAN_STEP_CYC = CLK_HZ / (CHAN_PWM_HZ * PWM_STEPS);
    localparam int GROUP_DIM_HZ = 190;
    localparam int GROUP_DIM_STEP_CYC = CLK_HZ / (GROUP_DIM_HZ * PWM_STEPS);
    localparam int BLINK_PER_SEC_DIV = 24;
    localparam int BLINK_UNIT_CYC = CLK_HZ / (BLINK_PER_SEC_DIV * PWM_STEPS);
    localparam int OSC_START_US = 500;
    localparam int OSC_START_CYC = (CLK_HZ / 1_000_000) * OSC_START_US;

    typedef enum logic [1:0] {
        OSC_OFF = 2'b00,
        OSC_START = 2'b01,
        OSC_RUN = 2'b10
    } ldb_osc_t;

endpackage

// [ldb_chan.sv]
// One LED channel: turns the shared step count, its duty value, its
// source selector and the group signal into an on request.
// Assumes the step count and the group signal come from the same clock.
`timescale 1ns/1ps
module ldb_chan (
    input wire logic [7:0] step,
    input wire logic [7:0] duty,
    input wire logic [1:0] src_sel,
    input wire logic group_on,
    output logic led_on
);
    import ldb_pkg::*;

    logic chan_pwm;

    // A zero duty never beats the count, so 00h stays dark and FFh
    // leaves one step of 256 off.
    assign chan_pwm = step < duty;

    always_comb begin
        led_on = 1'b0;
        unique case (src_sel)
            SRC_OFF: led_on = 1'b0;
            SRC_FULL_ON: led_on = 1'b1;
            SRC_CHAN_PWM: led_on = chan_pwm;
            SRC_CHAN_GROUP: led_on = chan_pwm & group_on;
        endcase
    end

endmodule

// [ldb_top.sv]
// Brightness engine of an eight-channel open-drain LED driver.
// Assumes the serial-bus slave runs on clk and hands over each written
// byte as a one-cycle strobe at its acknowledge, and the STOP as a pulse.
`timescale 1ns/1ps
module ldb_top #(
    parameter int BLINK_UNIT_CYCLES = ldb_pkg::BLINK_UNIT_CYC,
    parameter int OSC_START_CYCLES = ldb_pkg::OSC_START_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic stop_stb,
    input wire logic [4:0] rd_addr,
    output logic [7:0] rd_data,
    output logic osc_running,
    output logic [7:0] led_outputs_out,
    output logic [7:0] led_outputs_oe
);
    import ldb_pkg::*;

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [4:0] mode1_ff;
    logic group_blink_select_ff;
    logic update_on_ack_select_ff;
    logic [7:0] staged_ff [NUM_STAGED];
    logic [7:0] active_ff [NUM_STAGED];
    logic [7:0] rd_data_ff;
    logic sleep;
    logic wr_ok;
    logic wr_staged;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;

    assign sleep = mode1_ff[MODE1_SLEEP_BIT];
    // While asleep only the first mode register, which holds the wake
    // bit, accepts a write; every other register ignores it and keeps its value.
    assign wr_ok = wr_stb && (!sleep || wr_addr == ADDR_MODE1);
    assign wr_staged = wr_addr >= ADDR_LED0_DUTY && wr_addr <= ADDR_SRC_HIGH;
    assign wr_idx = 4'(wr_addr - ADDR_LED0_DUTY);
    assign rd_idx = 4'(rd_addr - ADDR_LED0_DUTY);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode1_ff <= MODE1_RESET;
        end else if (wr_ok && wr_addr == ADDR_MODE1) begin
            mode1_ff <= wr_data[4:0] & MODE1_WR_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            group_blink_select_ff <= 1'b0;
            update_on_ack_select_ff <= 1'b0;
        end else if (wr_ok && wr_addr == ADDR_SECOND_MODE) begin
            group_blink_select_ff <= wr_data[GROUP_BLINK_BIT];
            update_on_ack_select_ff <= wr_data[UPDATE_ON_ACK_BIT];
        end
    end

    // Writes land in the staging copy; the active copy that the
    // PWM logic sees follows either at each acknowledge or at STOP, so
    // several drivers on one bus can change their outputs together.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_STAGED; i++) begin
                staged_ff[i] <= DEFAULT_RESET;
            end
            staged_ff[IDX_GROUP_DUTY] <= GROUP_DUTY_RESET;
        end else if (wr_ok && wr_staged) begin
            staged_ff[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_STAGED; i++) begin
                active_ff[i] <= DEFAULT_RESET;
            end
            active_ff[IDX_GROUP_DUTY] <= GROUP_DUTY_RESET;
        end else if (!update_on_ack_select_ff && stop_stb) begin
            for (int i = 0; i < NUM_STAGED; i++) begin
                active_ff[i] <= staged_ff[i];
            end
        end else if (update_on_ack_select_ff && wr_ok && wr_staged) begin
            active_ff[wr_idx] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_ff <= 8'h00;
        end else if (rd_addr == ADDR_MODE1) begin
            rd_data_ff <= {3'h0, mode1_ff};
        end else if (rd_addr == ADDR_SECOND_MODE) begin
            rd_data_ff <= {2'h0, group_blink_select_ff, 1'b0, update_on_ack_select_ff, 3'h0};
        end else if (rd_addr >= ADDR_LED0_DUTY && rd_addr <= ADDR_SRC_HIGH) begin
            rd_data_ff <= staged_ff[rd_idx];
        end else begin
            rd_data_ff <= 8'h00;
        end
    end

    assign rd_data = rd_data_ff;

    // ----------------------------------------------------------------
    // Oscillator sleep and start-up
    // ----------------------------------------------------------------
    ldb_osc_t osc_state_ff;
    logic [16:0] osc_cnt_ff;
    logic run;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_state_ff <= OSC_OFF;
            osc_cnt_ff <= 17'h00000;
        end else if (sleep) begin
            osc_state_ff <= OSC_OFF;
            osc_cnt_ff <= 17'h00000;
        end else begin
            unique case (osc_state_ff)
                OSC_OFF: begin
                    osc_state_ff <= OSC_START;
                    osc_cnt_ff <= 17'h00000;
                end
                OSC_START: begin
                    // The wake write and the OFF state each take an edge, so the state turns two
                    // edges early to be visible within the start-up bound.
                    if (osc_cnt_ff >= 17'(OSC_START_CYCLES - 3)) begin
                        osc_state_ff <= OSC_RUN;
                    end
                    osc_cnt_ff <= osc_cnt_ff + 17'h00001;
                end
                OSC_RUN: osc_state_ff <= OSC_RUN;
                default: osc_state_ff <= OSC_OFF;
            endcase
        end
    end

    assign run = osc_state_ff == OSC_RUN;
    assign osc_running = run;

    // ----------------------------------------------------------------
    // Channel PWM timebase
    // ----------------------------------------------------------------
    logic [7:0] chan_div_ff;
    logic [7:0] chan_step_ff;

    // The PWM and group counters freeze with the oscillator, so no output edge can
    // appear while it is stopped.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_div_ff <= 8'h00;
            chan_step_ff <= 8'h00;
        end else if (run) begin
            if (chan_div_ff == 8'(CHAN_STEP_CYC - 1)) begin
                chan_div_ff <= 8'h00;
                chan_step_ff <= chan_step_ff + 8'h01;
            end else begin
                chan_div_ff <= chan_div_ff + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Group dimming and blinking
    // ----------------------------------------------------------------
    logic [15:0] grp_div_ff;
    logic [7:0] grp_rep_ff;
    logic [7:0] grp_step_ff;
    logic grp_unit_end;
    logic grp_step_end;
    logic group_on;

    // Dimming steps at a fixed rate and ignores the period register;
    // blinking repeats each unit period value plus one times per step.
    // The limits compare as at-or-above, so a mode switch or a smaller
    // period never leaves a counter past its end to wrap all the way round.
    assign grp_unit_end = group_blink_select_ff ?
        grp_div_ff >= 16'(BLINK_UNIT_CYCLES - 1) :
        grp_div_ff >= 16'(GROUP_DIM_STEP_CYC - 1);
    assign grp_step_end = grp_unit_end &&
        (!group_blink_select_ff || grp_rep_ff >= active_ff[IDX_GROUP_PERIOD]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            grp_div_ff <= 16'h0000;
            grp_rep_ff <= 8'h00;
            grp_step_ff <= 8'h00;
        end else if (run) begin
            if (grp_unit_end) begin
                grp_div_ff <= 16'h0000;
            end else begin
                grp_div_ff <= grp_div_ff + 16'h0001;
            end
            if (grp_step_end) begin
                grp_rep_ff <= 8'h00;
                grp_step_ff <= grp_step_ff + 8'h01;
            end else if (grp_unit_end) begin
                grp_rep_ff <= grp_rep_ff + 8'h01;
            end
        end
    end

    assign group_on = grp_step_ff < active_ff[IDX_GROUP_DUTY];

    // ----------------------------------------------------------------
    // Channels and open-drain drivers
    // ----------------------------------------------------------------
    logic [15:0] src_sel;
    logic [7:0] led_on;
    logic [7:0] led_oe_ff;

    assign src_sel = {active_ff[IDX_SRC_HIGH], active_ff[IDX_SRC_LOW]};

    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
        ldb_chan ldb_chan_inst (
            .step(chan_step_ff),
            .duty(active_ff[c]),
            .src_sel(src_sel[2 * c +: 2]),
            .group_on(group_on),
            .led_on(led_on[c])
        );
    end

    // Outputs hold their last state while the oscillator is off.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            led_oe_ff <= 8'h00;
        end else if (run) begin
            led_oe_ff <= led_on;
        end
    end

    assign led_outputs_oe = led_oe_ff;
    assign led_outputs_out = 8'h00;

endmodule

// [ldb_led_model.sv]
// LEDs with series resistors pulled up to the LED supply.
// Assumes open-drain pins: the enable high means the pin is pulled low.
`timescale 1ns/1ps
module ldb_led_model (
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] lit
);
    logic [7:0] pin;
    // A released pin floats up through the LED, so it reads high, not the last value.
    assign pin = (pin_oe & pin_out) | ~pin_oe;
    assign lit = ~pin;
endmodule

// [ldb_top_asserts.sv]
// Port checker for the LED brightness engine.
// Assumes it is bound to ldb_top and sees only its ports.
`timescale 1ns/1ps
module ldb_top_asserts #(
    parameter int BLINK_UNIT_CYCLES = 4,
    parameter int OSC_START_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_stb,
    input wire logic [4:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic stop_stb,
    input wire logic [4:0] rd_addr,
    input wire logic [7:0] rd_data,
    input wire logic osc_running,
    input wire logic [7:0] led_outputs_out,
    input wire logic [7:0] led_outputs_oe
);
    localparam int OSC_LIM = OSC_START_CYCLES;
    logic sleep_ff;
    // Writes to 00h are always taken, so this copy of the sleep bit stays exact.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sleep_ff <= 1'b1;
        end else if (wr_stb && wr_addr == 5'h00) begin
            sleep_ff <= wr_data[4];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_osc_bound:
        assert property (wr_stb && wr_addr == 5'h00 && !wr_data[4] && sleep_ff
            |-> ##[1:OSC_LIM] osc_running) else $error("oscillator late after wake");
    a_osc_wake:
        assert property ($rose(osc_running) |-> !sleep_ff) else $error("oscillator ran asleep");
    a_sleep_stop:
        assert property (wr_stb && wr_addr == 5'h00 && wr_data[4]
            |-> ##[1:2] !osc_running) else $error("oscillator kept running");
    a_frozen_asleep:
        assert property (!osc_running [*3] |-> $stable(led_outputs_oe))
            else $error("outputs moved while stopped");
    a_sleep_refuse:
        assert property (sleep_ff && wr_stb && wr_addr == 5'h02 && rd_addr == 5'h02
            ##1 rd_addr == 5'h02 && !wr_stb |=> $stable(rd_data))
            else $error("write taken while asleep");
    a_awake_store:
        assert property (!sleep_ff && wr_stb && wr_addr == 5'h02 && rd_addr == 5'h02
            ##1 rd_addr == 5'h02 && !wr_stb |=> rd_data == $past(wr_data, 2))
            else $error("duty write lost");
    a_mode_resv:
        assert property (rd_addr == 5'h01 |=> (rd_data & 8'hd7) == 8'h00)
            else $error("reserved mode bits set");
    a_pin_low:
        assert property (led_outputs_out == 8'h00) else $error("pin data not low");
endmodule

// [led_dimming_blinking_pwm_bench.sv]
// Self-checking bench for the LED brightness engine with LED loads.
// Assumes a 100 MHz clock and shortened blink and start-up counts.
`timescale 1ns/1ps
module led_dimming_blinking_pwm_bench;
    import ldb_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr_stb = 1'b0;
    logic [4:0] wr_addr = 5'h00;
    logic [7:0] wr_data = 8'h00;
    logic stop_stb = 1'b0;
    logic [4:0] rd_addr = 5'h00;
    logic [7:0] rd_data;
    logic osc_running;
    logic [7:0] led_outputs_out;
    logic [7:0] led_outputs_oe;
    logic [7:0] lit;
    int bad_count = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    ldb_top #(.BLINK_UNIT_CYCLES(4), .OSC_START_CYCLES(20)) ldb_top_inst (.clk(clk),
        .rst(rst), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
        .stop_stb(stop_stb), .rd_addr(rd_addr), .rd_data(rd_data),
        .osc_running(osc_running), .led_outputs_out(led_outputs_out),
        .led_outputs_oe(led_outputs_oe));
    ldb_led_model ldb_led_model_inst (.pin_out(led_outputs_out), .pin_oe(led_outputs_oe),
        .lit(lit));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        wr_stb = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_stb = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        rd_addr = a;
        @(negedge clk);
        d = rd_data;
    endtask
    task automatic meas(input int n, input int ch, output logic [15:0] on,
        output logic [15:0] ri);
        logic prev;
        on = 16'h0;
        ri = 16'h0;
        prev = lit[ch];
        repeat (n) begin
            @(negedge clk);
            on += lit[ch];
            ri += (lit[ch] && !prev);
            prev = lit[ch];
        end
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic t_reset();
        logic [7:0] d;
        logic [4:0] a [6] = '{5'h00, 5'h01, 5'h02, 5'h0a, 5'h0b, 5'h0c};
        logic [7:0] e [6] = '{8'h11, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(a[i], d);
            check("reset value", d, e[i]);
        end
        wr(5'h02, 8'h55);
        rd(5'h02, d);
        check("asleep write", d, 8'h00);
        check("dark asleep", lit, 8'h00);
        check("pin data", led_outputs_out, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_wake();
        int n = 0;
        wr(5'h00, 8'h01);
        // Duty registers stay untouched until the oscillator reports running.
        while (osc_running !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("wake in time", n <= 20, 16'h0001);
        $display("test wake done");
    endtask
    task automatic t_stop_update();
        logic [15:0] on, ri;
        logic [15:0] e [4] = '{16'h0400, 16'h0000, 16'h0800, 16'h0000};
        rd_addr = 5'h02;
        wr(5'h02, 8'h80);
        wr(5'h03, 8'h00);
        wr(5'h05, 8'hff);
        wr(5'h0c, 8'h1a);
        meas(64, 2, on, ri);
        check("held until stop", on, 16'h0000);
        @(negedge clk);
        stop_stb = 1'b1;
        @(negedge clk);
        stop_stb = 1'b0;
        for (int c = 0; c < 4; c++) begin
            meas(2048, c, on, ri);
            check("channel on time", on, e[c]);
        end
        meas(2048, 0, on, ri);
        check("pwm periods", ri, 16'h0002);
        $display("test stop update done");
    endtask
    task automatic t_ack_group();
        logic [7:0] d;
        logic [15:0] on, ri;
        wr(5'h01, 8'h08);
        rd(5'h01, d);
        check("ack mode", d, 8'h08);
        wr(5'h02, 8'h40);
        meas(2048, 0, on, ri);
        check("ack update", on, 16'h0200);
        wr(5'h0d, 8'h0b);
        wr(5'h06, 8'h80);
        wr(5'h07, 8'h80);
        wr(5'h0a, 8'h00);
        wr(5'h0b, 8'hff);
        meas(2048, 4, on, ri);
        check("group off", on, 16'h0000);
        meas(2048, 5, on, ri);
        check("no group", on, 16'h0400);
        $display("test ack group done");
    endtask
    task automatic t_blink();
        logic [7:0] d;
        logic [15:0] on, ri;
        int hi;
        wr(5'h01, 8'h28);
        rd(5'h01, d);
        check("blink mode", d, 8'h28);
        wr(5'h06, 8'hff);
        wr(5'h0a, 8'h80);
        for (int p = 0; p < 2; p++) begin
            wr(5'h0b, p[7:0]);
            hi = (p + 1) * 1024;
            meas(hi * 2, 4, on, ri);
            meas(hi * 2, 4, on, ri);
            check("blink on", on <= hi && on >= hi - (p + 1) * 8, 16'h0001);
        end
        $display("test blink done");
    endtask
    task automatic t_sleep();
        logic [7:0] d;
        logic [7:0] snap;
        rd_addr = 5'h02;
        wr(5'h00, 8'h11);
        repeat (3) @(negedge clk);
        snap = lit;
        wr(5'h02, 8'h55);
        rd(5'h02, d);
        check("asleep refuse", d, 8'h40);
        repeat (200) @(negedge clk);
        check("frozen leds", lit, snap);
        check("osc stopped", osc_running, 1'b0);
        $display("test sleep done");
    endtask
    initial begin
        #500_000;
        bad_count++;
        close_out();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_wake();
        t_stop_update();
        t_ack_group();
        t_blink();
        t_sleep();
        close_out();
    end
endmodule
bind ldb_top ldb_top_asserts #(.BLINK_UNIT_CYCLES(BLINK_UNIT_CYCLES),
    .OSC_START_CYCLES(OSC_START_CYCLES)) ldb_top_asserts_inst (.clk(clk), .rst(rst),
    .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .stop_stb(stop_stb),
    .rd_addr(rd_addr), .rd_data(rd_data), .osc_running(osc_running),
    .led_outputs_out(led_outputs_out), .led_outputs_oe(led_outputs_oe));
